/* File: include/pcr_pkg.sv */
/*
 * Constants of the converter configuration register bank: offsets,
 * field positions and built-in default values.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
// ==========================================================================
// Package
// ==========================================================================
package pcr_pkg;

   // Widths of the register access port, setup store and straps, and the setpoint count
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int SETUP_AW = 5;
   localparam int SETUP_DEPTH = 21;
   localparam int STRAP_W = 5;
   localparam int NUM_SETPOINTS = 3;

   // Setup register offsets
   localparam logic [7:0] PROTECTION_CONFIG_1 = 8'h00;
   localparam logic [7:0] PROTECTION_CONFIG_2 = 8'h01;
   localparam logic [7:0] PROTECTION_CONFIG_3 = 8'h02;
   localparam logic [7:0] TRACKING_CONFIG = 8'h03;
   localparam logic [7:0] SWITCHING_PHASE_FREQ_CONFIG = 8'h04;
   localparam logic [7:0] TURN_ON_DELAY = 8'h05;
   localparam logic [7:0] TURN_OFF_DELAY = 8'h06;
   localparam logic [7:0] VOLTAGE_LOOP_CONFIG = 8'h07;
   localparam logic [7:0] CURRENT_LIMIT_SETPOINT = 8'h08;
   localparam logic [7:0] DUTY_CYCLE_LIMIT = 8'h09;
   localparam logic [7:0] PROTECTION_CONFIG_4 = 8'h0a;
   localparam logic [7:0] SETPOINT1_UPPER = 8'h0b;
   localparam logic [7:0] SETPOINT1_LOWER = 8'h0c;
   localparam logic [7:0] SETPOINT2_UPPER = 8'h0d;
   localparam logic [7:0] SETPOINT2_LOWER = 8'h0e;
   localparam logic [7:0] SETPOINT3_UPPER = 8'h0f;
   localparam logic [7:0] SETPOINT3_LOWER = 8'h10;
   localparam logic [7:0] LOOP_PROPORTIONAL_COEFF = 8'h11;
   localparam logic [7:0] LOOP_INTEGRAL_COEFF = 8'h12;
   localparam logic [7:0] LOOP_DERIVATIVE_COEFF = 8'h13;
   localparam logic [7:0] DERIVATIVE_ROLLOFF_COEFF = 8'h14;
   localparam logic [7:0] SETUP_LAST = 8'h14;

   // Status and monitoring offsets
   localparam logic [7:0] OUTPUT_ENABLE_STATE = 8'h15;
   localparam logic [7:0] CONVERTER_CONDITION = 8'h16;
   localparam logic [7:0] VOUT_MONITOR_HIGH = 8'h17;
   localparam logic [7:0] OUTPUT_CURRENT_MONITOR = 8'h18;
   localparam logic [7:0] TEMPERATURE_MONITOR = 8'h19;
   localparam logic [7:0] VOUT_MONITOR_LOW = 8'h27;

   // Field positions
   localparam int RUN_ENABLE_BIT = 0;
   localparam int RUN_ACTIVE_BIT = 1;
   localparam int COND_PG_BIT = 0;
   localparam int COND_FAULT_BIT = 1;
   localparam int COND_CORE_LSB = 2;
   localparam int CORE_STATUS_W = 6;

   // Built-in defaults
   localparam logic [7:0] DEFAULT_ZERO = 8'h00;
   localparam logic [7:0] DEFAULT_TURN_OFF_DELAY = 8'h0b;
   localparam logic [15:0] DEFAULT_SETPOINT = 16'h0000;

endpackage : pcr_pkg

/* File: src/pcr_cfg_store.sv */
/*
 * Volatile byte store for the setup registers, one flop word per entry,
 * each reset to its own built-in default; read data from a register.
 * Assumes the writer has already filtered illegal or locked writes.
 */
`timescale 1ns/1ps
`default_nettype none

module pcr_cfg_store #(
   parameter int DEPTH = 21,
   parameter int WIDTH = 8,
   parameter int AW = 5,
   parameter logic [DEPTH*WIDTH-1:0] RESET_IMAGE = '0
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // Read port
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data_q,
   // Whole contents for the converter core
   output logic [DEPTH*WIDTH-1:0] image_q
);

   // ========================================================================
   // Storage
   // ========================================================================
   // Every entry returns to its default on reset
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            image_q[i*WIDTH +: WIDTH] <= RESET_IMAGE[i*WIDTH +: WIDTH];
         end else if (wr_en && (wr_addr == AW'(i))) begin
            image_q[i*WIDTH +: WIDTH] <= wr_data;
         end
      end
   end

   // Registered read; out of range reads as zero
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_data_q <= '0;
      end else if (32'(rd_addr) < DEPTH) begin
         rd_data_q <= image_q[rd_addr*WIDTH +: WIDTH];
      end else begin
         rd_data_q <= '0;
      end
   end

endmodule : pcr_cfg_store

`default_nettype wire

/* File: src/pcr_regs.sv */
/*
 * Configuration, status and monitoring register bank of a point-of-load
 * converter control chip, with address straps, power-good mirror and the
 * shared fault line.
 * Assumes a link decoder on sys_clk that turns the single-wire bus into
 * byte read and write strobes, and a converter core on the same clock.
 */
// What this block does
// - Five address straps form the bus address; ground is 0, open is 1.
// - Power-good pin level is mirrored into a condition register bit.
// - Setup registers are volatile, loaded over the link by the manager.
// - Loss of input power restores every register to its default.
// - Loop, frequency and duty limit change only with output off.
// - Fault line is a shared pulled-up line any member can pull low.
// - Setpoints written high byte first; low byte write loads whole word.
`timescale 1ns/1ps
`default_nettype none

module pcr_regs #(
   parameter int NUM_SP = pcr_pkg::NUM_SETPOINTS
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Byte access from the link decoder
   input wire logic [pcr_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [pcr_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_rd,
   output logic [pcr_pkg::DATA_W-1:0] reg_rdata_q,
   output logic reg_rvalid_q,
   // Address strap pins
   input wire logic [pcr_pkg::STRAP_W-1:0] address_strap_in,
   output logic [pcr_pkg::STRAP_W-1:0] bus_address_q,
   // Power-good pin, three signals
   input wire logic power_good_pin_in,
   output logic power_good_pin_out_q,
   output logic power_good_pin_oe_n_q,
   // Fault/status line, three signals
   input wire logic fault_line_in,
   output logic fault_line_out_q,
   output logic fault_line_oe_n_q,
   // Converter core
   input wire logic output_active,
   input wire logic power_not_good,
   input wire logic local_fault,
   input wire logic [pcr_pkg::CORE_STATUS_W-1:0] core_status,
   input wire logic [15:0] vout_mon,
   input wire logic [7:0] iout_mon,
   input wire logic [7:0] temp_mon,
   output logic [pcr_pkg::SETUP_DEPTH*8-1:0] setup_image_q,
   output logic [NUM_SP*16-1:0] setpoint_q,
   output logic run_enable_q,
   output logic group_fault_q
);

   // ========================================================================
   // Pin synchronisers
   // ========================================================================
   logic [pcr_pkg::STRAP_W-1:0] strap_s1_q;
   logic [pcr_pkg::STRAP_W-1:0] strap_s2_q;
   logic pg_s1_q;
   logic pg_s2_q;
   logic fault_s1_q;
   logic fault_s2_q;

   // Two flops on every pin before any logic
   always_ff @(posedge sys_clk) begin
      strap_s1_q <= address_strap_in;
      strap_s2_q <= strap_s1_q;
      pg_s1_q <= power_good_pin_in;
      pg_s2_q <= pg_s1_q;
      fault_s1_q <= fault_line_in;
      fault_s2_q <= fault_s1_q;
   end

   // Strap levels taken as the bus address, tracked on every edge outside reset
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bus_address_q <= '1;
      end else begin
         bus_address_q <= strap_s2_q;
      end
   end

   // ========================================================================
   // Open-drain pins
   // ========================================================================
   // Both pins only ever pull low; the pull-up makes the high level
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         power_good_pin_out_q <= 1'b0;
         power_good_pin_oe_n_q <= 1'b1;
         fault_line_out_q <= 1'b0;
         fault_line_oe_n_q <= 1'b1;
         group_fault_q <= 1'b0;
      end else begin
         power_good_pin_out_q <= 1'b0;
         power_good_pin_oe_n_q <= ~power_not_good;
         fault_line_out_q <= 1'b0;
         fault_line_oe_n_q <= ~local_fault;
         group_fault_q <= ~fault_s2_q;
      end
   end

   // ========================================================================
   // Write decode
   // ========================================================================
   wire in_setup = (reg_addr <= pcr_pkg::SETUP_LAST);
   wire restricted = (reg_addr == pcr_pkg::SWITCHING_PHASE_FREQ_CONFIG) ||
                     (reg_addr == pcr_pkg::DUTY_CYCLE_LIMIT) ||
                     ((reg_addr >= pcr_pkg::LOOP_PROPORTIONAL_COEFF) &&
                      (reg_addr <= pcr_pkg::DERIVATIVE_ROLLOFF_COEFF));
   // Output counts as on from the enable write until the core reports off
   wire output_on = run_enable_q | output_active;
   wire locked = restricted & output_on;
   wire store_wr = reg_wr & in_setup & ~locked;
   wire run_wr = reg_wr & (reg_addr == pcr_pkg::OUTPUT_ENABLE_STATE);

   // Default image of the setup registers
   localparam logic [pcr_pkg::SETUP_DEPTH*8-1:0] SETUP_DEFAULTS =
      {{(pcr_pkg::SETUP_DEPTH - 7){pcr_pkg::DEFAULT_ZERO}},
       pcr_pkg::DEFAULT_TURN_OFF_DELAY,
       {6{pcr_pkg::DEFAULT_ZERO}}};

   logic [7:0] store_rdata_q;

   // Volatile setup store, restored to defaults by reset
   pcr_cfg_store #(
      .DEPTH(pcr_pkg::SETUP_DEPTH),
      .WIDTH(8),
      .AW(pcr_pkg::SETUP_AW),
      .RESET_IMAGE(SETUP_DEFAULTS)
   ) u_store (
      .sys_clk(sys_clk),
      .srst(srst),
      .wr_en(store_wr),
      .wr_addr(reg_addr[pcr_pkg::SETUP_AW-1:0]),
      .wr_data(reg_wdata),
      .rd_addr(reg_addr[pcr_pkg::SETUP_AW-1:0]),
      .rd_data_q(store_rdata_q),
      .image_q(setup_image_q)
   );

   // ========================================================================
   // Run register
   // ========================================================================
   // Software-written enable that steers the core
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         run_enable_q <= 1'b0;
      end else if (run_wr) begin
         run_enable_q <= reg_wdata[pcr_pkg::RUN_ENABLE_BIT];
      end
   end

   // ========================================================================
   // Setpoint words
   // ========================================================================
   // High byte already sits in the store as shadow; low byte loads all 16
   for (genvar i = 0; i < NUM_SP; i++) begin : g_sp
      localparam logic [7:0] UP_ADDR = 8'(pcr_pkg::SETPOINT1_UPPER + 2 * i);
      localparam logic [7:0] LO_ADDR = 8'(pcr_pkg::SETPOINT1_LOWER + 2 * i);
      wire lo_wr = reg_wr & (reg_addr == LO_ADDR);
      wire [7:0] shadow_hi = setup_image_q[UP_ADDR*8 +: 8];
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            setpoint_q[i*16 +: 16] <= pcr_pkg::DEFAULT_SETPOINT;
         end else if (lo_wr) begin
            setpoint_q[i*16 +: 16] <= {shadow_hi, reg_wdata};
         end
      end
   end

   // ========================================================================
   // Status and read path
   // ========================================================================
   logic [7:0] cond_q;
   logic [7:0] vout_lo_snap_q;
   logic [7:0] rd_addr_q;
   logic rd_pend_q;

   // Condition register follows the synchronised pin levels
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cond_q <= 8'h00;
      end else begin
         cond_q[pcr_pkg::COND_PG_BIT] <= pg_s2_q;
         cond_q[pcr_pkg::COND_FAULT_BIT] <= fault_s2_q;
         cond_q[7:pcr_pkg::COND_CORE_LSB] <= core_status;
      end
   end

   // First read stage: store lookup and address capture
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_addr_q <= 8'h00;
         rd_pend_q <= 1'b0;
      end else begin
         rd_addr_q <= reg_addr;
         rd_pend_q <= reg_rd;
      end
   end

   // Read mux; unmapped offsets read as zero
   wire [7:0] run_view = {6'h00, output_active, run_enable_q};
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (rd_addr_q <= pcr_pkg::SETUP_LAST) begin
         rd_mux = store_rdata_q;
      end else begin
         unique case (rd_addr_q)
            pcr_pkg::OUTPUT_ENABLE_STATE: rd_mux = run_view;
            pcr_pkg::CONVERTER_CONDITION: rd_mux = cond_q;
            pcr_pkg::VOUT_MONITOR_HIGH: rd_mux = vout_mon[15:8];
            pcr_pkg::OUTPUT_CURRENT_MONITOR: rd_mux = iout_mon;
            pcr_pkg::TEMPERATURE_MONITOR: rd_mux = temp_mon;
            pcr_pkg::VOUT_MONITOR_LOW: rd_mux = vout_lo_snap_q;
            default: rd_mux = 8'h00;
         endcase
      end
   end

   // Reading the high monitor byte freezes its low byte for the next read
   wire snap_vout = rd_pend_q & (rd_addr_q == pcr_pkg::VOUT_MONITOR_HIGH);
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         vout_lo_snap_q <= 8'h00;
      end else if (snap_vout) begin
         vout_lo_snap_q <= vout_mon[7:0];
      end
   end

   // Second read stage: answer to the link decoder
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_rdata_q <= 8'h00;
         reg_rvalid_q <= 1'b0;
      end else begin
         reg_rdata_q <= rd_pend_q ? rd_mux : reg_rdata_q;
         reg_rvalid_q <= rd_pend_q;
      end
   end

   // ========================================================================
   // Assertions
   // ========================================================================
   localparam int CP_LSB = 8 * 17;
   localparam int DOF_LSB = 8 * 6;
   localparam int UP1_LSB = 8 * 11;

   // Locked coefficient keeps its value while output is on
   a_lock_holds: assert property (
      @(posedge sys_clk) disable iff (srst)
      (reg_wr && reg_addr == pcr_pkg::LOOP_PROPORTIONAL_COEFF && output_on)
      |=> $stable(setup_image_q[CP_LSB +: 8]))
      else $error("locked coefficient changed while output on");

   // Same write lands when output is off
   a_unlock_writes: assert property (
      @(posedge sys_clk) disable iff (srst)
      (reg_wr && reg_addr == pcr_pkg::LOOP_PROPORTIONAL_COEFF && !output_on)
      |=> setup_image_q[CP_LSB +: 8] == $past(reg_wdata))
      else $error("coefficient write lost with output off");

   // Low byte write loads shadow high byte and new low byte together
   a_sp_load: assert property (
      @(posedge sys_clk) disable iff (srst)
      (reg_wr && reg_addr == pcr_pkg::SETPOINT1_LOWER)
      |=> setpoint_q[15:0] ==
          {$past(setup_image_q[UP1_LSB +: 8]), $past(reg_wdata)})
      else $error("setpoint not loaded on low byte write");

   // High byte write alone leaves the active setpoint untouched
   a_sp_shadow: assert property (
      @(posedge sys_clk) disable iff (srst)
      (reg_wr && reg_addr == pcr_pkg::SETPOINT1_UPPER)
      |=> $stable(setpoint_q[15:0]))
      else $error("setpoint changed on high byte write");

   // Reset brings back the defaults
   a_reset_dflt: assert property (
      @(posedge sys_clk)
      $past(srst) |-> (setup_image_q[DOF_LSB +: 8] ==
                       pcr_pkg::DEFAULT_TURN_OFF_DELAY) &&
                      (setpoint_q == '0) && !run_enable_q)
      else $error("register not at default after reset");

   // Strap level reaches the address three edges later
   a_strap_addr: assert property (
      @(posedge sys_clk) disable iff (srst)
      !$past(srst) && !$past(srst, 2) && !$past(srst, 3)
      |-> bus_address_q == $past(address_strap_in, 3))
      else $error("bus address does not follow straps");

   // Power-good pin level appears in the condition register
   a_pg_mirror: assert property (
      @(posedge sys_clk) disable iff (srst)
      !$past(srst) && !$past(srst, 2) && !$past(srst, 3)
      |-> cond_q[pcr_pkg::COND_PG_BIT] == $past(power_good_pin_in, 3))
      else $error("power good bit does not mirror pin");

   // Local fault pulls the shared line low next edge
   a_fault_pull: assert property (
      @(posedge sys_clk) disable iff (srst)
      local_fault |=> !fault_line_oe_n_q && !fault_line_out_q)
      else $error("fault line not pulled low");

   // Every read answers two edges later
   a_read_lat: assert property (
      @(posedge sys_clk) disable iff (srst)
      reg_rd |-> ##2 reg_rvalid_q)
      else $error("read answer missing");

   // Scenarios worth seeing
   c_sp_load: cover property (
      @(posedge sys_clk) disable iff (srst)
      reg_wr && reg_addr == pcr_pkg::SETPOINT1_UPPER
      ##[1:20] reg_wr && reg_addr == pcr_pkg::SETPOINT1_LOWER);
   c_locked_try: cover property (
      @(posedge sys_clk) disable iff (srst)
      reg_wr && locked);
   c_cond_read: cover property (
      @(posedge sys_clk) disable iff (srst)
      reg_rd && reg_addr == pcr_pkg::CONVERTER_CONDITION ##2 reg_rvalid_q);

endmodule : pcr_regs

`default_nettype wire

/* File: dv/pcr_mgr_model.sv */
/*
 * Manager-side model: issues byte writes and reads toward the bank.
 * Assumes its tasks are called just after a rising edge of sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module pcr_mgr_model (
   // Clock
   input wire logic sys_clk,
   // Byte access toward the bank
   output logic [pcr_pkg::ADDR_W-1:0] reg_addr,
   output logic reg_wr,
   output logic [pcr_pkg::DATA_W-1:0] reg_wdata,
   output logic reg_rd
);
   // ======================================================================
   // Idle state and access tasks
   // ======================================================================
   // Strobes idle low; released lines carry scrambled values
   initial begin
      reg_addr = 8'h5a;
      reg_wr = 1'b0;
      reg_wdata = 8'ha5;
      reg_rd = 1'b0;
   end

   // One write strobe, then one idle cycle
   task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
      @(posedge sys_clk);
      #1;
   endtask : write_byte

   // One read strobe, then one idle cycle
   task automatic read_byte(input logic [7:0] a);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(posedge sys_clk);
      #1;
   endtask : read_byte
endmodule : pcr_mgr_model

`default_nettype wire

/* File: dv/tb_pcr_regs.sv */
/*
 * Self-checking bench for the register bank.
 * Assumes the manager model drives byte access; pins resolved here.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_pcr_regs;
   // ======================================================================
   // Signals
   // ======================================================================
   logic sys_clk, srst, reg_wr, reg_rd, reg_rvalid_q;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_q, iout_mon, temp_mon;
   logic [4:0] address_strap_in, bus_address_q;
   logic power_good_pin_in, power_good_pin_out_q, power_good_pin_oe_n_q;
   logic fault_line_in, fault_line_out_q, fault_line_oe_n_q;
   logic output_active, power_not_good, local_fault, pg_ext, fault_ext;
   logic [5:0] core_status;
   logic [15:0] vout_mon;
   logic [167:0] setup_image_q;
   logic [47:0] setpoint_q;
   logic run_enable_q, group_fault_q, run_exp;
   logic [7:0] mem [0:20];
   logic [15:0] sp [0:2];
   logic [7:0] snap;
   logic [7:0] exp_q [$];
   int num_errors, n_compared, cyc, seed;

   // Clock and pulled-up shared lines
   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;
   assign power_good_pin_in = pg_ext & power_good_pin_oe_n_q;
   assign fault_line_in = fault_ext & fault_line_oe_n_q;

   pcr_mgr_model i_mgr (.sys_clk(sys_clk), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

   pcr_regs i_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
      .address_strap_in(address_strap_in), .bus_address_q(bus_address_q),
      .power_good_pin_in(power_good_pin_in),
      .power_good_pin_out_q(power_good_pin_out_q),
      .power_good_pin_oe_n_q(power_good_pin_oe_n_q),
      .fault_line_in(fault_line_in), .fault_line_out_q(fault_line_out_q),
      .fault_line_oe_n_q(fault_line_oe_n_q), .output_active(output_active),
      .power_not_good(power_not_good), .local_fault(local_fault),
      .core_status(core_status), .vout_mon(vout_mon), .iout_mon(iout_mon),
      .temp_mon(temp_mon), .setup_image_q(setup_image_q),
      .setpoint_q(setpoint_q), .run_enable_q(run_enable_q),
      .group_fault_q(group_fault_q));

   // ======================================================================
   // Checking and reporting
   // ======================================================================
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // Oldest noted read result against each read answer, mid-cycle
   always @(negedge sys_clk) begin
      if (reg_rvalid_q === 1'b1) begin
         if (exp_q.size() == 0)
            chk(48'(reg_rdata_q), 48'hbad);
         else
            chk(48'(reg_rdata_q), 48'(exp_q.pop_front()));
      end
   end

   // Hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end

   // ======================================================================
   // Stimulus tasks and expectation model
   // ======================================================================
   task automatic cyc_wait(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc_wait

   task automatic set_defaults();
      for (int n = 0; n <= 20; n++)
         mem[n] = (n == 6) ? 8'h0b : 8'h00;
      for (int i = 0; i < 3; i++)
         sp[i] = 16'h0000;
      run_exp = 1'b0;
      snap = 8'h00;
   endtask : set_defaults

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic lk;
      lk = run_exp | output_active;
      if (a <= 8'h14 && !(lk && (a == 8'h04 || a == 8'h09 || a >= 8'h11)))
         mem[a] = d;
      if (a == 8'h0c || a == 8'h0e || a == 8'h10)
         sp[(a - 8'h0c) >> 1] = {mem[a - 8'h01], d};
      if (a == 8'h15)
         run_exp = d[0];
      i_mgr.write_byte(a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      logic [7:0] e;
      case (a)
         8'h15: e = {6'h00, output_active, run_exp};
         8'h16: e = {core_status, fault_ext & ~local_fault,
                     pg_ext & ~power_not_good};
         8'h17: e = vout_mon[15:8];
         8'h18: e = iout_mon;
         8'h19: e = temp_mon;
         8'h27: e = snap;
         default: e = (a <= 8'h14) ? mem[a] : 8'h00;
      endcase
      if (a == 8'h17)
         snap = vout_mon[7:0];
      exp_q.push_back(e);
      i_mgr.read_byte(a);
   endtask : rd

   task automatic check_outs();
      cyc_wait(4);
      for (int n = 0; n <= 20; n++)
         chk(48'(setup_image_q[8*n +: 8]), 48'(mem[n]));
      chk(setpoint_q, {sp[2], sp[1], sp[0]});
      chk(48'(run_enable_q), 48'(run_exp));
      chk(48'(exp_q.size()), 48'h0);
   endtask : check_outs

   // Write every setup register in ascending order, read all back
   task automatic prog_all();
      for (int n = 0; n <= 20; n++)
         wr(8'(n), 8'($urandom));
      for (int n = 0; n <= 21; n++)
         rd(8'(n));
      check_outs();
   endtask : prog_all

   // ======================================================================
   // Main sequence
   // ======================================================================
   initial begin
      {srst, output_active, power_not_good, local_fault} = 4'h8;
      {pg_ext, fault_ext} = 2'b11;
      address_strap_in = 5'h1f;
      core_status = 6'h00;
      vout_mon = 16'h0000;
      {iout_mon, temp_mon} = 16'h0000;
      seed = $urandom(32'h539a);
      set_defaults();
      cyc_wait(3);
      srst = 1'b0;
      for (int n = 0; n <= 21; n++)
         rd(8'(n));
      check_outs();
      chk(48'(bus_address_q), 48'h1f);
      $display("test defaults done");
      prog_all();
      wr(8'h0c, 8'($urandom));
      check_outs();
      $display("test program done");
      wr(8'h15, 8'($urandom) | 8'h01);
      prog_all();
      wr(8'h15, 8'($urandom) & 8'hfe);
      output_active = 1'b1;
      prog_all();
      output_active = 1'b0;
      prog_all();
      $display("test lock done");
      {vout_mon, iout_mon, temp_mon} = 32'($urandom);
      foreach (mem[n])
         mem[n] = mem[n];
      wr(8'h16, 8'hff);
      wr(8'h17, 8'hff);
      wr(8'h27, 8'hff);
      wr(8'h30, 8'h5a);
      rd(8'h17);
      rd(8'h18);
      rd(8'h19);
      rd(8'h27);
      rd(8'h30);
      check_outs();
      $display("test monitors done");
      for (int k = 0; k < 8; k++) begin
         address_strap_in = 5'($urandom);
         {pg_ext, fault_ext, power_not_good, local_fault} = 4'($urandom);
         core_status = 6'($urandom);
         cyc_wait(5);
         chk(48'(bus_address_q), 48'(address_strap_in));
         chk(48'(power_good_pin_oe_n_q), 48'(!power_not_good));
         chk(48'(fault_line_oe_n_q), 48'(!local_fault));
         chk(48'(group_fault_q), 48'(!(fault_ext && !local_fault)));
         chk(48'({power_good_pin_out_q, fault_line_out_q}), 48'h0);
         rd(8'h16);
      end
      check_outs();
      $display("test pins done");
      prog_all();
      srst = 1'b1;
      cyc_wait(2);
      srst = 1'b0;
      set_defaults();
      for (int n = 0; n <= 21; n++)
         rd(8'(n));
      check_outs();
      $display("test reset done");
      report_and_stop();
   end
endmodule : tb_pcr_regs

`default_nettype wire
